// ===== src/otc_pkg.sv
// Purpose: shared constants and helpers for the oscillator trim block
// Assumes: 32-bit register words, byte addresses
// Notes:   percent figures are carried in tenths of a percent

// ---------------------------------------------------------------
// register map and field layout
// ---------------------------------------------------------------
package otc_pkg;

  // register byte offsets
  localparam logic [11:0] OFS_KEY  = 12'h000;
  localparam logic [11:0] OFS_EN   = 12'h004;
  localparam logic [11:0] OFS_FACT = 12'h008;
  localparam logic [11:0] OFS_USER = 12'h00C;

  // write key field
  localparam int          KEY_W      = 8;
  localparam logic [7:0]  UNLOCK_KEY = 8'hC1;
  localparam logic [7:0]  KEY_RST    = 8'h00;

  // trim fields, same layout in factory and user registers
  localparam int          COARSE_LSB = 8;
  localparam int          COARSE_W   = 6;
  localparam int          FINE_LSB   = 0;
  localparam int          FINE_W     = 4;
  localparam int          EN_BIT     = 0;

  // values after reset
  localparam logic [5:0]  USER_COARSE_RST = 6'h00;
  localparam logic [3:0]  USER_FINE_RST   = 4'h0;
  localparam logic        EN_RST          = 1'b0;
  localparam logic [31:0] RD_RST          = 32'h0000_0000;

  // frequency step per code, tenths of a percent
  localparam int          PCT_W       = 11;
  localparam logic signed [10:0] COARSE_STEP = 11'sh012;
  localparam logic signed [10:0] FINE_STEP   = 11'sh003;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // coarse code as signed step count times step size
  function automatic logic signed [10:0] coarse_pct(input logic [5:0] c);
    return $signed({{5{c[5]}}, c}) * COARSE_STEP;
  endfunction

  // fine code as signed step count times step size
  function automatic logic signed [10:0] fine_pct(input logic [3:0] f);
    return $signed({{7{f[3]}}, f}) * FINE_STEP;
  endfunction

  // place coarse and fine codes into a register word
  function automatic logic [31:0] pack_trim(input logic [5:0] c,
                                            input logic [3:0] f);
    return {18'h00000, c, 4'h0, f};
  endfunction

endpackage

// ===== src/otc_key_guard.sv
// Purpose: holds the write key and decides whether trim writes pass
// Assumes: write strobe is one cycle long
// Notes:   lock state is derived from the stored key only
`timescale 1ns/100ps

// ---------------------------------------------------------------
// key register
// ---------------------------------------------------------------
module otc_key_guard (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // key write
  input  wire logic        wr_key,
  input  wire logic [7:0]  wr_val,
  // key state
  output logic      [7:0]  key_ff,
  output logic             unlocked
);

  // key store, always writable
  always_ff @(posedge clk) begin
    if (rst) begin
      key_ff <= otc_pkg::KEY_RST;
    end else if (wr_key) begin
      key_ff <= wr_val;
    end
  end

  assign unlocked = (key_ff == otc_pkg::UNLOCK_KEY);

endmodule

// ===== src/otc_code_sel.sv
// Purpose: picks factory or user trim codes and drives the oscillator
// Assumes: all inputs on the same clock
// Notes:   outputs change one cycle after their sources
`timescale 1ns/100ps

// ---------------------------------------------------------------
// code selector
// ---------------------------------------------------------------
module otc_code_sel (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // selection
  input  wire logic               use_user,
  // code sources
  input  wire logic        [5:0]  fact_c,
  input  wire logic        [3:0]  fact_f,
  input  wire logic        [5:0]  user_c,
  input  wire logic        [3:0]  user_f,
  // oscillator side
  output logic             [5:0]  coarse_ff,
  output logic             [3:0]  fine_ff,
  output logic signed      [10:0] pct_ff,
  output logic                    user_ff
);

  logic        [5:0]  nxt_coarse;
  logic        [3:0]  nxt_fine;

  assign nxt_coarse = use_user ? user_c : fact_c;
  assign nxt_fine   = use_user ? user_f : fact_f;

  // registered codes to the oscillator
  always_ff @(posedge clk) begin
    if (rst) begin
      coarse_ff <= 6'h00;
      fine_ff   <= 4'h0;
      user_ff   <= 1'b0;
    end else begin
      coarse_ff <= nxt_coarse;
      fine_ff   <= nxt_fine;
      user_ff   <= use_user;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pct_ff <= 11'sh000;
    end else begin
      pct_ff <= otc_pkg::coarse_pct(nxt_coarse) + otc_pkg::fine_pct(nxt_fine);
    end
  end

endmodule

// ===== src/otc_trim_ctrl.sv
// Purpose: register block for internal oscillator trim selection
// Assumes: factory codes arrive as static pins from fuses
// Notes:   register reads answer one cycle after the read strobe
`timescale 1ns/100ps

// Summary of operation
// - enable and user trim writes pass only while key holds C1
// - after reset key is zero so trim writes stay blocked
// - oscillator gets factory codes when select bit 0, user codes when 1
// - factory coarse reads at bits 13-8, fine at bits 3-0
// - user coarse in bits 13-8, fine in 3-0, both reset zero
// - coarse code is signed, 1.8 percent per step
// - fine code is signed, 0.3 percent per step
module otc_trim_ctrl #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input  wire logic                CLK,
  input  wire logic                SYS_RST,
  // register port
  input  wire logic [ADDR_W-1:0]   ADDR,
  input  wire logic [31:0]         WR_DATA,
  input  wire logic                WR_EN,
  input  wire logic                RD_EN,
  output logic      [31:0]         RD_DATA,
  // factory trim fuses
  input  wire logic [5:0]          FACTORY_COARSE,
  input  wire logic [3:0]          FACTORY_FINE,
  // oscillator trim inputs
  output logic      [5:0]          OSC_COARSE,
  output logic      [3:0]          OSC_FINE,
  output logic signed [10:0]       TRIM_PCT_X10,
  output logic                     USER_ACTIVE
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (ADDR_W < 4) begin : g_addr_chk
    $error("ADDR_W too small for register map");
  end

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic        [5:0]  fact_c_meta_ff;
  logic        [3:0]  fact_f_meta_ff;
  logic        [5:0]  fact_c_ff;
  logic        [3:0]  fact_f_ff;
  logic        [7:0]  key_q;
  logic               unlocked;
  logic               hit_key;
  logic               hit_en;
  logic               hit_fact;
  logic               hit_user;
  logic               use_user_code_ff;
  logic        [5:0]  user_c_ff;
  logic        [3:0]  user_f_ff;
  logic        [31:0] nxt_rd_data;
  logic        [31:0] rd_data_ff;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  // full compare, anything else is unmapped
  assign hit_key  = (ADDR == ADDR_W'(otc_pkg::OFS_KEY));
  assign hit_en   = (ADDR == ADDR_W'(otc_pkg::OFS_EN));
  assign hit_fact = (ADDR == ADDR_W'(otc_pkg::OFS_FACT));
  assign hit_user = (ADDR == ADDR_W'(otc_pkg::OFS_USER));

  // ---------------------------------------------------------------
  // factory code capture
  // ---------------------------------------------------------------
  // two-stage sync of the fuse pins
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      fact_c_meta_ff <= 6'h00;
      fact_f_meta_ff <= 4'h0;
      fact_c_ff      <= 6'h00;
      fact_f_ff      <= 4'h0;
    end else begin
      fact_c_meta_ff <= FACTORY_COARSE;
      fact_f_meta_ff <= FACTORY_FINE;
      fact_c_ff      <= fact_c_meta_ff;
      fact_f_ff      <= fact_f_meta_ff;
    end
  end

  // ---------------------------------------------------------------
  // write key
  // ---------------------------------------------------------------
  // key clears at reset
  otc_key_guard u_key (
    .clk      (CLK),
    .rst      (SYS_RST),
    .wr_key   (WR_EN && hit_key),
    .wr_val   (WR_DATA[7:0]),
    .key_ff   (key_q),
    .unlocked (unlocked)
  );

  // ---------------------------------------------------------------
  // trim select enable
  // ---------------------------------------------------------------
  // gated by key
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      use_user_code_ff <= otc_pkg::EN_RST;
    end else if (WR_EN && hit_en && unlocked) begin
      use_user_code_ff <= WR_DATA[otc_pkg::EN_BIT];
    end
  end

  // ---------------------------------------------------------------
  // user trim value
  // ---------------------------------------------------------------
  // fields reset zero
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      user_c_ff <= otc_pkg::USER_COARSE_RST;
      user_f_ff <= otc_pkg::USER_FINE_RST;
    end else if (WR_EN && hit_user && unlocked) begin
      user_c_ff <= WR_DATA[otc_pkg::COARSE_LSB +: otc_pkg::COARSE_W];
      user_f_ff <= WR_DATA[otc_pkg::FINE_LSB +: otc_pkg::FINE_W];
    end
  end

  // ---------------------------------------------------------------
  // oscillator code select
  // ---------------------------------------------------------------
  // factory or user
  otc_code_sel u_sel (
    .clk       (CLK),
    .rst       (SYS_RST),
    .use_user  (use_user_code_ff),
    .fact_c    (fact_c_ff),
    .fact_f    (fact_f_ff),
    .user_c    (user_c_ff),
    .user_f    (user_f_ff),
    .coarse_ff (OSC_COARSE),
    .fine_ff   (OSC_FINE),
    .pct_ff    (TRIM_PCT_X10),
    .user_ff   (USER_ACTIVE)
  );

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // factory fields placed
  always_comb begin
    nxt_rd_data = otc_pkg::RD_RST;
    if (RD_EN) begin
      if (hit_key) begin
        nxt_rd_data = {24'h000000, key_q};
      end else if (hit_en) begin
        nxt_rd_data = {31'h00000000, use_user_code_ff};
      end else if (hit_fact) begin
        nxt_rd_data = otc_pkg::pack_trim(fact_c_ff, fact_f_ff);
      end else if (hit_user) begin
        nxt_rd_data = otc_pkg::pack_trim(user_c_ff, user_f_ff);
      end
    end
  end

  // read data only in the cycle after the strobe
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rd_data_ff <= otc_pkg::RD_RST;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign RD_DATA = rd_data_ff;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // write to a trim register while locked
  sequence s_locked_trim_wr;
    WR_EN && !unlocked && (hit_en || hit_user);
  endsequence

  // user value write that the key lets through
  sequence s_open_user_wr;
    WR_EN && hit_user && unlocked;
  endsequence

  // user write with codes live, then no enable write behind it
  sequence s_live_user_wr;
    (WR_EN && hit_user && unlocked && use_user_code_ff) ##1 !(WR_EN && hit_en);
  endsequence

  // accepted enable write, then no second enable write
  sequence s_open_en_wr;
    (WR_EN && hit_en && unlocked) ##1 !(WR_EN && hit_en);
  endsequence

  AST_LOCKED_NO_CHANGE: assert property (@(posedge CLK) disable iff (SYS_RST)
    s_locked_trim_wr |=> $stable(use_user_code_ff) && $stable(user_c_ff)
                         && $stable(user_f_ff))
    else $error("trim register changed while locked");

  AST_UNLOCK_WRITE: assert property (@(posedge CLK) disable iff (SYS_RST)
    s_open_user_wr |=> user_c_ff == $past(WR_DATA[13:8])
                       && user_f_ff == $past(WR_DATA[3:0]))
    else $error("user trim write lost after unlock");

  AST_WRONG_KEY: assert property (@(posedge CLK) disable iff (SYS_RST)
    (WR_EN && hit_key && WR_DATA[7:0] != 8'hC1) |=> !unlocked)
    else $error("wrong key unlocked trim writes");

  AST_RESET_LOCKED: assert property (@(posedge CLK)
    SYS_RST |=> key_q == 8'h00 && !use_user_code_ff
                && user_c_ff == 6'h00 && user_f_ff == 4'h0)
    else $error("trim block not locked after reset");

  AST_SEL_FACTORY: assert property (@(posedge CLK) disable iff (SYS_RST)
    !use_user_code_ff |=> OSC_COARSE == $past(fact_c_ff)
                          && OSC_FINE == $past(fact_f_ff) && !USER_ACTIVE)
    else $error("oscillator not on factory codes");

  AST_SEL_USER: assert property (@(posedge CLK) disable iff (SYS_RST)
    use_user_code_ff |=> OSC_COARSE == $past(user_c_ff)
                         && OSC_FINE == $past(user_f_ff) && USER_ACTIVE)
    else $error("oscillator not on user codes");

  AST_FACT_READ: assert property (@(posedge CLK) disable iff (SYS_RST)
    (RD_EN && hit_fact) |=> RD_DATA[13:8] == $past(fact_c_ff)
                            && RD_DATA[3:0] == $past(fact_f_ff))
    else $error("factory trim read wrong");

  AST_USER_READ: assert property (@(posedge CLK) disable iff (SYS_RST)
    (RD_EN && hit_user) |=> RD_DATA[13:8] == $past(user_c_ff)
                            && RD_DATA[3:0] == $past(user_f_ff))
    else $error("user trim read wrong");

  AST_COARSE_PCT: assert property (@(posedge CLK) disable iff (SYS_RST)
    (OSC_FINE == 4'h0 && OSC_COARSE == 6'h20) |-> TRIM_PCT_X10 == -11'sd576)
    else $error("coarse minimum step wrong");

  AST_FINE_PCT: assert property (@(posedge CLK) disable iff (SYS_RST)
    (OSC_COARSE == 6'h1F && OSC_FINE == 4'h8) |-> TRIM_PCT_X10 == 11'sd534)
    else $error("fine step sum wrong");

  AST_RSVD_ZERO: assert property (@(posedge CLK) disable iff (SYS_RST)
    RD_DATA[31:14] == 18'h00000
    && (RD_DATA[7:4] == 4'h0 || ($past(RD_EN) && $past(hit_key)))
    && (RD_DATA == 32'h0000_0000 || $past(RD_EN)))
    else $error("reserved read bits not zero");

  AST_KEY_STORE: assert property (@(posedge CLK) disable iff (SYS_RST)
    (WR_EN && hit_key) |=> key_q == $past(WR_DATA[7:0]))
    else $error("key write not stored");

  AST_EN_WRITE: assert property (@(posedge CLK) disable iff (SYS_RST)
    (WR_EN && hit_en && unlocked) |=> use_user_code_ff == $past(WR_DATA[0]))
    else $error("enable write lost after unlock");

  AST_FACT_NO_WRITE: assert property (@(posedge CLK) disable iff (SYS_RST)
    (WR_EN && hit_fact) |=> $stable(use_user_code_ff) && $stable(user_c_ff)
                            && $stable(user_f_ff) && $stable(key_q))
    else $error("factory register write changed state");

  AST_USER_FOLLOW: assert property (@(posedge CLK) disable iff (SYS_RST)
    s_live_user_wr |=> OSC_COARSE == $past(WR_DATA[13:8], 2)
                       && OSC_FINE == $past(WR_DATA[3:0], 2) && USER_ACTIVE)
    else $error("user codes not at oscillator");

  AST_EN_FOLLOW: assert property (@(posedge CLK) disable iff (SYS_RST)
    s_open_en_wr |=> USER_ACTIVE == $past(WR_DATA[0], 2))
    else $error("enable write not at oscillator");

  // key read shows stored byte only
  AST_KEY_READ: assert property (@(posedge CLK) disable iff (SYS_RST)
    (RD_EN && hit_key) |=> RD_DATA == {24'h000000, $past(key_q)})
    else $error("key read wrong");

  // enable read shows bit 0 only
  AST_EN_READ: assert property (@(posedge CLK) disable iff (SYS_RST)
    (RD_EN && hit_en) |=> RD_DATA == {31'h0, $past(use_user_code_ff)})
    else $error("enable read wrong");

  AST_UNMAPPED_READ: assert property (@(posedge CLK) disable iff (SYS_RST)
    (RD_EN && !hit_key && !hit_en && !hit_fact && !hit_user)
    |=> RD_DATA == 32'h0000_0000)
    else $error("unmapped read not zero");

endmodule

// ===== dv/otc_osc_model.sv
// Purpose: fuse pins and oscillator response beside the trim block
// Assumes: trim codes are two's complement
// Notes:   frequency offset in tenths of a percent
`timescale 1ns/100ps

// ---------------------------------------------------------------
// oscillator model
// ---------------------------------------------------------------
module otc_osc_model #(
  parameter logic [5:0] FUSE_C = 6'h2A,
  parameter logic [3:0] FUSE_F = 4'h5
) (
  // fuse pins
  output logic      [5:0] fuse_c,
  output logic      [3:0] fuse_f,
  // trim inputs
  input  wire logic [5:0] osc_c,
  input  wire logic [3:0] osc_f,
  // modelled offset
  output int              freq_x10
);
  assign fuse_c = FUSE_C;
  assign fuse_f = FUSE_F;
  assign freq_x10 = $signed(osc_c) * 18 + $signed(osc_f) * 3;
endmodule

// ===== dv/test_internal_osc_trim_ctrl.sv
// Purpose: self-checking bench for the oscillator trim registers
// Assumes: read data stands only in the cycle after the read strobe
// Notes:   fuse codes come from the oscillator model
`timescale 1ns/100ps

module test_internal_osc_trim_ctrl;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam logic [5:0] FC = 6'h2A;
  localparam logic [3:0] FF = 4'h5;
  logic               clk   = 1'b0;
  logic               rst   = 1'b1;
  logic [11:0]        addr  = 12'h000;
  logic [31:0]        wdata = 32'h0000_0000;
  logic               wen   = 1'b0;
  logic               ren   = 1'b0;
  logic [31:0]        rdata;
  logic [5:0]         fc;
  logic [5:0]         oc;
  logic [3:0]         ff;
  logic [3:0]         of;
  logic signed [10:0] pct;
  logic               ua;
  int                 freq;
  int                 n_errors   = 0;
  int                 num_checks = 0;
  int                 cyc        = 0;

  // clock
  always #50 clk = ~clk;

  otc_trim_ctrl otc_trim_ctrl_i (
    .CLK(clk), .SYS_RST(rst), .ADDR(addr), .WR_DATA(wdata), .WR_EN(wen),
    .RD_EN(ren), .RD_DATA(rdata), .FACTORY_COARSE(fc), .FACTORY_FINE(ff),
    .OSC_COARSE(oc), .OSC_FINE(of), .TRIM_PCT_X10(pct), .USER_ACTIVE(ua));

  otc_osc_model #(.FUSE_C(FC), .FUSE_F(FF)) otc_osc_model_i (
    .fuse_c(fc), .fuse_f(ff), .osc_c(oc), .osc_f(of), .freq_x10(freq));

  // ---------------------------------------------------------------
  // bus and compare tasks
  // ---------------------------------------------------------------
  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wen   <= 1'b1;
    @(posedge clk);
    wen   <= 1'b0;
  endtask

  task automatic chk_rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    ren  <= 1'b1;
    @(posedge clk);
    ren  <= 1'b0;
    #1;
    num_checks++;
    if (rdata !== exp) begin
      n_errors++;
      $display("MISMATCH %0t read %h got %h exp %h", $time, a, rdata, exp);
    end
  endtask

  task automatic chk_osc(input logic [5:0] c, input logic [3:0] f, input logic u);
    logic signed [10:0] p;
    p = 11'($signed(c) * 18 + $signed(f) * 3);
    repeat (2) @(posedge clk);
    #1;
    num_checks++;
    if ({oc, of, ua, pct} !== {c, f, u, p} || freq !== int'(p)) begin
      n_errors++;
      $display("MISMATCH %0t osc %h %h %b %0d exp %h %h %b %0d",
               $time, oc, of, ua, pct, c, f, u, p);
    end
  endtask

  task automatic do_reset;
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    chk_rd(otc_pkg::OFS_KEY, 32'h0000_0000);
    chk_rd(otc_pkg::OFS_EN, 32'h0000_0000);
    chk_rd(otc_pkg::OFS_FACT, {18'h00000, FC, 4'h0, FF});
    chk_rd(otc_pkg::OFS_USER, 32'h0000_0000);
    chk_osc(FC, FF, 1'b0);
  endtask

  task automatic t_locked;
    wr(otc_pkg::OFS_USER, 32'h0000_1F07);
    wr(otc_pkg::OFS_EN, 32'h0000_0001);
    chk_rd(otc_pkg::OFS_USER, 32'h0000_0000);
    chk_rd(otc_pkg::OFS_EN, 32'h0000_0000);
    wr(otc_pkg::OFS_KEY, 32'h0000_00C0);
    wr(otc_pkg::OFS_USER, 32'h0000_1F07);
    wr(otc_pkg::OFS_EN, 32'h0000_0001);
    chk_rd(otc_pkg::OFS_KEY, 32'h0000_00C0);
    chk_rd(otc_pkg::OFS_USER, 32'h0000_0000);
    chk_osc(FC, FF, 1'b0);
  endtask

  task automatic t_unlock;
    wr(otc_pkg::OFS_KEY, 32'hFFFF_FFC1);
    chk_rd(otc_pkg::OFS_KEY, 32'h0000_00C1);
    wr(otc_pkg::OFS_USER, 32'hFFFF_FFFF);
    wr(otc_pkg::OFS_FACT, 32'h0000_0000);
    chk_rd(otc_pkg::OFS_USER, 32'h0000_3F0F);
    chk_rd(otc_pkg::OFS_FACT, {18'h00000, FC, 4'h0, FF});
    chk_osc(FC, FF, 1'b0);
    wr(otc_pkg::OFS_EN, 32'hFFFF_FFFF);
    chk_rd(otc_pkg::OFS_EN, 32'h0000_0001);
    chk_osc(6'h3F, 4'hF, 1'b1);
  endtask

  task automatic t_codes;
    logic [5:0] cs [4] = '{6'h1F, 6'h20, 6'h01, 6'h00};
    logic [3:0] fs [4] = '{4'h8, 4'h0, 4'h7, 4'h0};
    for (int i = 0; i < 4; i++) begin
      wr(otc_pkg::OFS_USER, {18'h00000, cs[i], 4'h0, fs[i]});
      chk_osc(cs[i], fs[i], 1'b1);
    end
  endtask

  task automatic t_relock;
    wr(otc_pkg::OFS_USER, 32'h0000_0504);
    wr(otc_pkg::OFS_EN, 32'h0000_0000);
    chk_osc(FC, FF, 1'b0);
    chk_rd(12'h010, 32'h0000_0000);
    wr(otc_pkg::OFS_KEY, 32'h0000_0000);
    wr(otc_pkg::OFS_EN, 32'h0000_0001);
    chk_rd(otc_pkg::OFS_EN, 32'h0000_0000);
    chk_rd(otc_pkg::OFS_USER, 32'h0000_0504);
    // reset rises on a clock edge
    @(posedge clk);
    do_reset();
    chk_rd(otc_pkg::OFS_USER, 32'h0000_0000);
    wr(otc_pkg::OFS_EN, 32'h0000_0001);
    chk_rd(otc_pkg::OFS_EN, 32'h0000_0000);
    chk_osc(FC, FF, 1'b0);
  endtask

  // ---------------------------------------------------------------
  // sequence and timeout
  // ---------------------------------------------------------------
  // main sequence
  initial begin
    do_reset();
    t_reset();
    t_locked();
    t_unlock();
    t_codes();
    t_relock();
    print_verdict();
  end

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      $display("MISMATCH %0t timeout", $time);
      print_verdict();
    end
  end
endmodule
